// File: hw/mdrc_pkg.sv
package mdrc_pkg;

    // timing: clock rate and reset pin pulse width
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned RST_PULSE_NS   = 40;
    localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam int unsigned PULSE_CNT_W    = 4;
    localparam int unsigned SYNC_STAGES    = 2;

    // register byte offsets
    localparam int unsigned ADDR_W         = 8;
    localparam logic [7:0]  OFS_CFG        = 8'h00;
    localparam logic [7:0]  OFS_CTRL_STS   = 8'h04;
    localparam logic [7:0]  OFS_SOFT_RST   = 8'h08;
    localparam logic [7:0]  OFS_DEV_CFG    = 8'h0c;
    localparam logic [7:0]  OFS_CAUSE      = 8'h10;
    localparam logic [7:0]  OFS_DEV_STS    = 8'h14;
    localparam logic [7:0]  OFS_BOOT       = 8'h18;

    // ahb transfer type
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
    localparam logic [1:0]  HTRANS_SEQ     = 2'b11;

    // reset configuration register, bit 5 downward
    typedef struct packed {
        logic ana_release;    // bit 5
        logic ctrl_release;   // bit 4
        logic prop_shared;    // bit 3
        logic prop_ctrl;      // bit 2
        logic analog_bus_rst; // bit 1
        logic ctrl_rst_req;   // bit 0
    } mdrc_cfg_s;
    localparam int unsigned CFG_W          = 6;
    localparam logic [5:0]  CFG_RST        = 6'h00;

    // control reset status fields
    localparam int unsigned CST_LIVE       = 0;
    localparam int unsigned CST_SEEN       = 1;

    // reset cause fields
    localparam int unsigned CAUSE_BOARD    = 0;
    localparam int unsigned CAUSE_POR      = 1;
    localparam int unsigned CAUSE_WDT0     = 2;
    localparam int unsigned CAUSE_WDT1     = 3;
    localparam int unsigned CAUSE_SW       = 4;
    localparam int unsigned CAUSE_NMI      = 5;
    localparam int unsigned CAUSE_DBG      = 6;
    localparam int unsigned CAUSE_W        = 7;
    localparam logic [6:0]  CAUSE_RST      = 7'h02;

    // device status fields
    localparam int unsigned DST_ACIB       = 0;
    localparam int unsigned DST_BOARD      = 1;

    // boot status fields
    localparam int unsigned BOOT_MODE_W    = 4;
    localparam int unsigned BOOT_VALID     = 4;
    localparam int unsigned BOOT_IDLE      = 5;

    // reset domain indices; peripherals start at DOM_FIXED
    localparam int unsigned DOM_MSYS       = 0;
    localparam int unsigned DOM_CCPU       = 1;
    localparam int unsigned DOM_SRX        = 2;
    localparam int unsigned DOM_ANA        = 3;
    localparam int unsigned DOM_ACIB       = 4;
    localparam int unsigned DOM_FIXED      = 5;

    // boot release tracking
    typedef enum logic [1:0] {
        BT_HELD,
        BT_SAMPLE,
        BT_RUN
    } mdrc_boot_e;

endpackage : mdrc_pkg

// File: hw/mdrc_rst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mdrc_rst_sync #(
    parameter int unsigned STAGES = 2
) (
    // clock
    input  wire logic core_clk,
    // asynchronous assert request, active high
    input  wire logic assert_in,
    // synchronised reset, active high
    output logic      rst_out
);

    logic [STAGES-1:0] chain_q;

    // assert at once, release after STAGES clean edges
    always_ff @(posedge core_clk or posedge assert_in) begin
        if (assert_in) begin
            chain_q <= '1;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], 1'b0};
        end
    end

    assign rst_out = chain_q[STAGES-1];

endmodule : mdrc_rst_sync

`default_nettype wire

// File: hw/mdrc_top.sv
// Function
// - board pin low resets master and control
// - drive board pin on por or watchdogs
// - analog pin resets analog; analog por drives it
// - por or system reset restarts master cpu
// - system reset reaches master peripherals
// - system reset from pin, watchdogs, soft, debug
// - soft and debug resets routed onward
// - config bits reset control and analog bus
// - status bit shows control system reset
// - peripheral soft reset gated by enable
// - cause register accumulates reset sources until cleared
// - control cpu reset drives control system reset
// - control cpu reset has five sources
// - soft and debug reach control when enabled
// - device status shows bus reset, pin
// - shared reset: pin, enabled soft and debug
// - analog also reset by bus reset, pin
// - parallel bus interface follows system reset
// - control and analog held until released
// - control idles until boot wake interrupt
// - boot mode pins sampled after release
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module mdrc_top #(
    parameter int unsigned NUM_PERIPH = 8
) (
    // clock and power-on reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // board reset pin, open drain
    input  wire logic                    board_reset_pin_in_n,
    output logic                         board_reset_pin_out,
    output logic                         board_reset_pin_oe_n,
    // analog reset pin, open drain
    input  wire logic                    analog_reset_pin_in_n,
    output logic                         analog_reset_pin_out,
    output logic                         analog_reset_pin_oe_n,
    input  wire logic                    analog_por,
    // reset event sources
    input  wire logic                    master_wdt0_timeout,
    input  wire logic                    master_wdt1_timeout,
    input  wire logic                    master_nmi_wdt_timeout,
    input  wire logic                    master_software_reset,
    input  wire logic                    master_debugger_reset,
    input  wire logic                    control_nmi_watchdog_reset,
    // boot handshake
    input  wire logic                    boot_wake_interrupt,
    input  wire logic [3:0]              boot_mode_pins,
    output logic                         control_idle_hold,
    // domain resets, active high
    output logic                         master_cpu_reset,
    output logic                         master_system_reset,
    output logic                         parallel_bus_interface_reset,
    output logic [NUM_PERIPH-1:0]        peripheral_reset,
    output logic                         control_cpu_reset_input,
    output logic                         control_system_reset,
    output logic                         shared_resource_reset,
    output logic                         analog_subsystem_reset,
    output logic                         analog_bus_reset
);

    localparam int unsigned NDOM = mdrc_pkg::DOM_FIXED + NUM_PERIPH;
    localparam logic [mdrc_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
        mdrc_pkg::PULSE_CNT_W'(mdrc_pkg::RST_PULSE_CYC);

    mdrc_pkg::mdrc_cfg_s         cfg_q;
    mdrc_pkg::mdrc_boot_e        boot_q;
    logic [NDOM-1:0]             raw_d;
    logic [NDOM-1:0]             raw_q;
    logic [NDOM-1:0]             dom_rst;
    logic [NUM_PERIPH-1:0]       soft_q;
    logic [NUM_PERIPH-1:0]       enable_q;
    logic [mdrc_pkg::CAUSE_W-1:0] cause_q;
    logic [mdrc_pkg::CAUSE_W-1:0] cause_set;
    logic [mdrc_pkg::PULSE_CNT_W-1:0] brd_cnt_q;
    logic [mdrc_pkg::PULSE_CNT_W-1:0] ana_cnt_q;
    logic [mdrc_pkg::BOOT_MODE_W-1:0] boot_mode_q;
    logic                        boot_valid_q;
    logic                        idle_q;
    logic                        ctrl_sys_q;
    logic                        ctrl_seen_q;
    logic                        wr_pend_q;
    logic [7:0]                  wr_addr_q;
    logic [31:0]                 rdata_q;
    logic [31:0]                 rdata;
    logic                        addr_ok;
    logic                        wr_en;
    logic                        board_in;
    logic                        analog_in;
    logic                        wdog_any;
    logic                        swdbg;
    logic                        msys_raw;
    logic                        ctrl_raw;
    logic                        srx_raw;
    logic                        rst_msys;

    // pin levels and combined watchdog
    assign board_in = ~board_reset_pin_in_n;
    assign analog_in = ~analog_reset_pin_in_n;
    assign wdog_any = master_wdt0_timeout | master_wdt1_timeout | master_nmi_wdt_timeout;
    assign swdbg    = master_software_reset | master_debugger_reset;

    // system reset sources; pin covers master and control
    assign msys_raw = board_in | wdog_any | swdbg;
    assign ctrl_raw = board_in | control_nmi_watchdog_reset
                    | (swdbg & cfg_q.prop_ctrl)
                    | cfg_q.ctrl_rst_req
                    | ~cfg_q.ctrl_release;
    assign srx_raw  = board_in | (swdbg & cfg_q.prop_shared);

    // per-domain raw reset requests
    always_comb begin
        raw_d = '0;
        raw_d[mdrc_pkg::DOM_MSYS] = msys_raw;
        raw_d[mdrc_pkg::DOM_CCPU] = ctrl_raw;
        raw_d[mdrc_pkg::DOM_SRX]  = srx_raw;
        raw_d[mdrc_pkg::DOM_ANA]  = srx_raw | cfg_q.analog_bus_rst | analog_in
                                  | ~cfg_q.ana_release;
        raw_d[mdrc_pkg::DOM_ACIB] = cfg_q.analog_bus_rst | ~cfg_q.ana_release;
        raw_d[NDOM-1:mdrc_pkg::DOM_FIXED] = {NUM_PERIPH{msys_raw}}
                                          | (soft_q & enable_q);
    end

    // register requests so the async assert path sees no glitches
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            raw_q <= '1;
        end else begin
            raw_q <= raw_d;
        end
    end

    // one synchroniser per domain
    genvar gi;
    generate
        for (gi = 0; gi < NDOM; gi++) begin : g_dom
            mdrc_rst_sync #(
                .STAGES    (mdrc_pkg::SYNC_STAGES)
            ) u_sync (
                .core_clk  (core_clk),
                .assert_in (reset | raw_q[gi]),
                .rst_out   (dom_rst[gi])
            );
        end
    endgenerate

    assign rst_msys = dom_rst[mdrc_pkg::DOM_MSYS];

    // domain outputs; master cpu restarts from its reset vector on release
    assign master_cpu_reset             = rst_msys;
    assign master_system_reset          = rst_msys;
    assign parallel_bus_interface_reset = rst_msys;
    assign peripheral_reset             = dom_rst[NDOM-1:mdrc_pkg::DOM_FIXED];
    assign control_cpu_reset_input      = dom_rst[mdrc_pkg::DOM_CCPU];
    assign shared_resource_reset        = dom_rst[mdrc_pkg::DOM_SRX];
    assign analog_subsystem_reset       = dom_rst[mdrc_pkg::DOM_ANA];
    assign analog_bus_reset             = dom_rst[mdrc_pkg::DOM_ACIB];
    assign control_system_reset         = ctrl_sys_q;

    // control cpu passes its reset on to its subsystem a cycle later
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_sys_q <= 1'b1;
        end else begin
            ctrl_sys_q <= dom_rst[mdrc_pkg::DOM_CCPU];
        end
    end

    // board pin pulse: starts at power-on, reloads on watchdog timeout
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            brd_cnt_q <= PULSE_LOAD;
        end else if (wdog_any) begin
            brd_cnt_q <= PULSE_LOAD;
        end else if (brd_cnt_q != '0) begin
            brd_cnt_q <= brd_cnt_q - 1'b1;
        end
    end

    assign board_reset_pin_out  = 1'b0;
    assign board_reset_pin_oe_n = (brd_cnt_q == '0);

    // analog pin pulse driven by the analog power-on reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ana_cnt_q <= PULSE_LOAD;
        end else if (analog_por) begin
            ana_cnt_q <= PULSE_LOAD;
        end else if (ana_cnt_q != '0) begin
            ana_cnt_q <= ana_cnt_q - 1'b1;
        end
    end

    assign analog_reset_pin_out  = 1'b0;
    assign analog_reset_pin_oe_n = (ana_cnt_q == '0);

    // ahb address phase decode
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_en   = wr_pend_q;

    // capture write address phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[mdrc_pkg::ADDR_W-1:0];
        end
    end

    // reset configuration; master reset clears the release bits
    always_ff @(posedge core_clk or posedge rst_msys) begin
        if (rst_msys) begin
            cfg_q <= mdrc_pkg::mdrc_cfg_s'(mdrc_pkg::CFG_RST);
        end else if (wr_en && wr_addr_q == mdrc_pkg::OFS_CFG) begin
            cfg_q <= mdrc_pkg::mdrc_cfg_s'(hwdata[mdrc_pkg::CFG_W-1:0]);
        end
    end

    // peripheral soft reset bits and their enables
    always_ff @(posedge core_clk or posedge rst_msys) begin
        if (rst_msys) begin
            soft_q   <= '0;
            enable_q <= '0;
        end else if (wr_en) begin
            if (wr_addr_q == mdrc_pkg::OFS_SOFT_RST) begin
                soft_q <= hwdata[NUM_PERIPH-1:0];
            end
            if (wr_addr_q == mdrc_pkg::OFS_DEV_CFG) begin
                enable_q <= hwdata[NUM_PERIPH-1:0];
            end
        end
    end

    // control reset seen: sticky, write one to clear, set wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_seen_q <= 1'b0;
        end else if (ctrl_sys_q) begin
            ctrl_seen_q <= 1'b1;
        end else if (wr_en && wr_addr_q == mdrc_pkg::OFS_CTRL_STS
                     && hwdata[mdrc_pkg::CST_SEEN]) begin
            ctrl_seen_q <= 1'b0;
        end
    end

    // reset cause events; pin counts only when driven from outside
    always_comb begin
        cause_set = '0;
        cause_set[mdrc_pkg::CAUSE_BOARD] = board_in & board_reset_pin_oe_n;
        cause_set[mdrc_pkg::CAUSE_WDT0]  = master_wdt0_timeout;
        cause_set[mdrc_pkg::CAUSE_WDT1]  = master_wdt1_timeout;
        cause_set[mdrc_pkg::CAUSE_SW]    = master_software_reset;
        cause_set[mdrc_pkg::CAUSE_NMI]   = master_nmi_wdt_timeout;
        cause_set[mdrc_pkg::CAUSE_DBG]   = master_debugger_reset;
    end

    // cause register survives system reset, cleared by writing ones
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cause_q <= mdrc_pkg::CAUSE_RST;
        end else if (wr_en && wr_addr_q == mdrc_pkg::OFS_CAUSE) begin
            cause_q <= (cause_q & ~hwdata[mdrc_pkg::CAUSE_W-1:0]) | cause_set;
        end else begin
            cause_q <= cause_q | cause_set;
        end
    end

    // boot tracking: wait for both releases, then sample mode pins once
    always_ff @(posedge core_clk or posedge rst_msys) begin
        if (rst_msys) begin
            boot_q <= mdrc_pkg::BT_HELD;
        end else begin
            case (boot_q)
                mdrc_pkg::BT_HELD: begin
                    if (cfg_q.ctrl_release && cfg_q.ana_release) begin
                        boot_q <= mdrc_pkg::BT_SAMPLE;
                    end
                end
                mdrc_pkg::BT_SAMPLE: begin
                    boot_q <= mdrc_pkg::BT_RUN;
                end
                mdrc_pkg::BT_RUN: begin
                    boot_q <= mdrc_pkg::BT_RUN;
                end
                default: begin
                    boot_q <= mdrc_pkg::BT_HELD;
                end
            endcase
        end
    end

    // latched boot mode
    always_ff @(posedge core_clk or posedge rst_msys) begin
        if (rst_msys) begin
            boot_mode_q  <= '0;
            boot_valid_q <= 1'b0;
        end else if (boot_q == mdrc_pkg::BT_SAMPLE) begin
            boot_mode_q  <= boot_mode_pins;
            boot_valid_q <= 1'b1;
        end
    end

    // control held idle from reset and during control system reset, until the next wake interrupt
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            idle_q <= 1'b1;
        end else if (ctrl_sys_q) begin
            idle_q <= 1'b1;
        end else if (boot_wake_interrupt) begin
            idle_q <= 1'b0;
        end
    end

    assign control_idle_hold = idle_q;

    // read data mux, unmapped offsets read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (haddr[mdrc_pkg::ADDR_W-1:0])
            mdrc_pkg::OFS_CFG: begin
                rdata[mdrc_pkg::CFG_W-1:0] = cfg_q;
            end
            mdrc_pkg::OFS_CTRL_STS: begin
                rdata[mdrc_pkg::CST_LIVE] = ctrl_sys_q;
                rdata[mdrc_pkg::CST_SEEN] = ctrl_seen_q;
            end
            mdrc_pkg::OFS_SOFT_RST: begin
                rdata[NUM_PERIPH-1:0] = soft_q;
            end
            mdrc_pkg::OFS_DEV_CFG: begin
                rdata[NUM_PERIPH-1:0] = enable_q;
            end
            mdrc_pkg::OFS_CAUSE: begin
                rdata[mdrc_pkg::CAUSE_W-1:0] = cause_q;
            end
            mdrc_pkg::OFS_DEV_STS: begin
                rdata[mdrc_pkg::DST_ACIB]  = dom_rst[mdrc_pkg::DOM_ACIB];
                rdata[mdrc_pkg::DST_BOARD] = board_reset_pin_in_n;
            end
            mdrc_pkg::OFS_BOOT: begin
                rdata[mdrc_pkg::BOOT_MODE_W-1:0] = boot_mode_q;
                rdata[mdrc_pkg::BOOT_VALID]      = boot_valid_q;
                rdata[mdrc_pkg::BOOT_IDLE]       = idle_q;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data sampled in the address phase, held for the data phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            rdata_q <= rdata;
        end
    end

    // zero wait state, always okay
    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule : mdrc_top

`default_nettype wire

// File: test/mdrc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module mdrc_board_model (
    // clock and power-on
    input  wire logic core_clk,
    input  wire logic reset,
    // open-drain pins
    input  wire logic brd_out,
    input  wire logic brd_oe_n,
    input  wire logic brd_ext_low,
    output logic      brd_in_n,
    input  wire logic ana_out,
    input  wire logic ana_oe_n,
    output logic      ana_in_n
);
    logic [3:0] pwr_q;

    // board holds pin low eight clocks
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) pwr_q <= 4'h8;
        else if (pwr_q != 4'h0) pwr_q <= pwr_q - 4'h1;
    end

    // wired-and, pulled up when free
    assign brd_in_n = !((!brd_oe_n && !brd_out) || brd_ext_low || pwr_q != 4'h0);
    assign ana_in_n = !(!ana_oe_n && !ana_out);
endmodule : mdrc_board_model

`default_nettype wire

// File: test/mdrc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module mdrc_top_chk #(
    parameter int unsigned NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  reset,
    // pins and events
    input wire logic                  board_reset_pin_in_n,
    input wire logic                  board_reset_pin_oe_n,
    input wire logic                  analog_reset_pin_in_n,
    input wire logic                  analog_reset_pin_oe_n,
    input wire logic                  analog_por,
    input wire logic                  master_wdt0_timeout,
    input wire logic                  master_wdt1_timeout,
    input wire logic                  master_nmi_wdt_timeout,
    // domain resets
    input wire logic                  master_system_reset,
    input wire logic                  parallel_bus_interface_reset,
    input wire logic [NUM_PERIPH-1:0] peripheral_reset,
    input wire logic                  control_cpu_reset_input,
    input wire logic                  control_system_reset,
    input wire logic                  analog_subsystem_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // pin and domain resets
    chk_wdt_drives_pin: assert property (
        (master_wdt0_timeout || master_wdt1_timeout || master_nmi_wdt_timeout)
        |=> !board_reset_pin_oe_n) else $error("pin idle");
    chk_por_drives_ana: assert property (analog_por |=> !analog_reset_pin_oe_n)
        else $error("analog pin idle");
    chk_pin_to_master: assert property (
        !board_reset_pin_in_n |-> ##[0:2] master_system_reset) else $error("no system reset");
    chk_pin_to_control: assert property (
        !board_reset_pin_in_n |-> ##[0:2] control_cpu_reset_input) else $error("no cpu reset");
    chk_ana_pin_reset: assert property (
        !analog_reset_pin_in_n |-> ##[0:2] analog_subsystem_reset) else $error("no analog reset");
    chk_ctrl_sys_lag: assert property (
        $rose(control_cpu_reset_input) |=> control_system_reset) else $error("system lag");
    chk_periph_follow: assert property (
        $rose(master_system_reset) |-> ##[0:2] (&peripheral_reset)) else $error("periph free");
    chk_pbi_follow: assert property (
        parallel_bus_interface_reset == master_system_reset) else $error("pbi reset differs");
    chk_held_after: assert property (
        $fell(master_system_reset) |-> control_cpu_reset_input && analog_subsystem_reset)
        else $error("domains not held");
    chk_sync_release: assert property (
        $fell(master_system_reset) |-> $past(board_reset_pin_in_n, 2)) else $error("early release");

    cover property (master_wdt0_timeout);
    cover property ($rose(control_cpu_reset_input));
    cover property ($fell(master_system_reset));
endmodule : mdrc_top_chk

bind mdrc_top mdrc_top_chk #(.NUM_PERIPH(NUM_PERIPH)) i_mdrc_top_chk (
    .core_clk, .reset, .board_reset_pin_in_n, .board_reset_pin_oe_n, .analog_reset_pin_in_n,
    .analog_reset_pin_oe_n, .analog_por, .master_wdt0_timeout, .master_wdt1_timeout,
    .master_nmi_wdt_timeout, .master_system_reset, .parallel_bus_interface_reset,
    .peripheral_reset, .control_cpu_reset_input, .control_system_reset, .analog_subsystem_reset);

`default_nettype wire

// File: test/multi_domain_reset_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none

module multi_domain_reset_controller_bench;
    logic        core_clk = 0, reset = 1, hsel = 0, hwrite = 0, aps = 0, wake = 0, cnmi = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, b_out, b_oe_n, b_in_n, a_out, a_oe_n, a_in_n, icl;
    logic        msr, mcr, pbr, ccr, csr, srr, asr, abr;
    logic [7:0]  pr, pe, ps;
    logic [5:0]  ev = 6'h0;
    logic [3:0]  bmode = 4'h0;
    int          err_count = 0, comparisons = 0;
    int          cidx [6] = '{mdrc_pkg::CAUSE_WDT0, mdrc_pkg::CAUSE_WDT1, mdrc_pkg::CAUSE_NMI,
                              mdrc_pkg::CAUSE_SW, mdrc_pkg::CAUSE_DBG, mdrc_pkg::CAUSE_BOARD};

    mdrc_top #(.NUM_PERIPH(8)) i_mdrc_top (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .board_reset_pin_in_n(b_in_n), .board_reset_pin_out(b_out), .board_reset_pin_oe_n(b_oe_n),
        .analog_reset_pin_in_n(a_in_n), .analog_reset_pin_out(a_out),
        .analog_reset_pin_oe_n(a_oe_n), .analog_por(aps), .master_wdt0_timeout(ev[0]),
        .master_wdt1_timeout(ev[1]), .master_nmi_wdt_timeout(ev[2]),
        .master_software_reset(ev[3]), .master_debugger_reset(ev[4]),
        .control_nmi_watchdog_reset(cnmi), .boot_wake_interrupt(wake), .boot_mode_pins(bmode),
        .control_idle_hold(icl), .master_cpu_reset(mcr), .master_system_reset(msr),
        .parallel_bus_interface_reset(pbr), .peripheral_reset(pr), .control_cpu_reset_input(ccr),
        .control_system_reset(csr), .shared_resource_reset(srr), .analog_subsystem_reset(asr),
        .analog_bus_reset(abr));

    mdrc_board_model i_mdrc_board_model (.core_clk, .reset, .brd_out(b_out), .brd_oe_n(b_oe_n),
        .brd_ext_low(ev[5]), .brd_in_n(b_in_n), .ana_out(a_out), .ana_oe_n(a_oe_n),
        .ana_in_n(a_in_n));

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // one ahb transfer, read data to rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= mdrc_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // wait for master release
    task automatic settle;
        repeat (80) if (msr) @(posedge core_clk);
    endtask : settle

    task automatic conclude;
        $display("counts: %0d compared, %0d bad", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // hang guard
    initial begin
        #50000;
        err_count++;
        conclude();
    end

    initial begin
        void'($urandom(32'h8be29748));
        bmode <= 4'($urandom);
        tick(16);
        reset <= 1'b0;
        settle();
        chk(32'({ccr, asr, icl}), 32'h7);
        bus(1'b0, mdrc_pkg::OFS_CAUSE, 32'h0);
        chk(rd & 32'h2, 32'h2);
        bus(1'b1, mdrc_pkg::OFS_CAUSE, 32'h7f);
        bus(1'b0, mdrc_pkg::OFS_CAUSE, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("done power-up and map");
        bus(1'b1, mdrc_pkg::OFS_CFG, 32'h30);
        tick(6);
        chk(32'({ccr, asr, abr}), 32'h0);
        bus(1'b0, mdrc_pkg::OFS_BOOT, 32'h0);
        chk(rd, 32'h30 | 32'(bmode));
        wake <= 1'b1;
        tick(1);
        wake <= 1'b0;
        tick(3);
        bus(1'b0, mdrc_pkg::OFS_BOOT, 32'h0);
        chk(rd, 32'h10 | 32'(bmode));
        $display("done boot release");
        bus(1'b1, mdrc_pkg::OFS_CFG, 32'h31);
        tick(3);
        chk(32'(ccr), 32'h1);
        bus(1'b0, mdrc_pkg::OFS_CTRL_STS, 32'h0);
        chk(rd, 32'h3);
        bus(1'b1, mdrc_pkg::OFS_CFG, 32'h32);
        tick(3);
        chk(32'({abr, asr}), 32'h3);
        bus(1'b0, mdrc_pkg::OFS_DEV_STS, 32'h0);
        chk(rd, 32'h3);
        bus(1'b1, mdrc_pkg::OFS_CFG, 32'h30);
        tick(6);
        bus(1'b1, mdrc_pkg::OFS_CTRL_STS, 32'h2);
        bus(1'b0, mdrc_pkg::OFS_CTRL_STS, 32'h0);
        chk(rd, 32'h0);
        cnmi <= 1'b1;
        tick(2);
        chk(32'({ccr, msr}), 32'h2);
        cnmi <= 1'b0;
        tick(6);
        bus(1'b0, mdrc_pkg::OFS_CTRL_STS, 32'h0);
        chk(rd, 32'h2);
        aps <= 1'b1;
        tick(1);
        aps <= 1'b0;
        tick(2);
        chk(32'(asr), 32'h1);
        $display("done selective resets");
        for (int i = 0; i < 5; i++) begin
            pe = (i == 0) ? 8'h00 : 8'($urandom);
            ps = (i == 1) ? 8'hff : 8'($urandom);
            bus(1'b1, mdrc_pkg::OFS_DEV_CFG, 32'(pe));
            bus(1'b1, mdrc_pkg::OFS_SOFT_RST, 32'(ps));
            tick(4);
            chk(32'(pr), 32'(ps & pe));
        end
        $display("done peripheral resets");
        for (int k = 0; k < 6; k++) begin
            if (k == 3) bus(1'b1, mdrc_pkg::OFS_CFG, 32'h08);
            ev[k] <= 1'b1;
            tick(2);
            ev <= 6'h0;
            tick(1);
            chk(32'({msr, mcr}), 32'h3);
            chk(32'(srr), 32'(k != 4));
            settle();
            bus(1'b0, mdrc_pkg::OFS_CAUSE, 32'h0);
            chk(rd, 32'h1 << cidx[k]);
            bus(1'b1, mdrc_pkg::OFS_CAUSE, 32'h7f);
        end
        $display("done reset sources");
        conclude();
    end
endmodule : multi_domain_reset_controller_bench

`default_nettype wire
